// File: power_serial_pkg.sv
// Shared constants for the power and serial-format register bank
// Behaviour
// - Sleep register bit 7 picks analog core supply: 0 external, 1 on-chip regulator.
// - Reference precharge code 0..3 lasts 3.5, 10, 50 or 100 ms.
// - Broadcast enable bit makes the device also answer at bus address 1001100.
// - Sleep register bit 0 at 0 keeps sleep; resets to 0, device starts asleep.
// - Input capacitor precharge code 0..3 lasts 2.5, 12.5, 25 or 50 ms.
// - Protocol code 0 TDM, 1 I2S, 2 left-justified; code 3 must not be used.
// - Slot word length code 0..3 gives 16, 20, 24, 32 bits; resets to 32.
// - Bits 3 and 2 invert frame-sync and bit-clock polarity when set.
// - Transmit edge bit set launches each bit on the sample edge, half a bit clock before the default edge would.
// - Unused bit-clock cycles drive low when fill bit is 0, float when 1.
// - Page register at offset 0x0 selects the page; these registers live on page 0.
// - Writing 1 to the self-clearing restore bit returns every register to reset.
package power_serial_pkg;

	// ---------------------------------------------------------------
	// Register offsets and reset values
	// ---------------------------------------------------------------
	localparam logic [7:0] OFS_PAGE    = 8'h00;
	localparam logic [7:0] OFS_RESTORE = 8'h01;
	localparam logic [7:0] OFS_SLEEP   = 8'h02;
	localparam logic [7:0] OFS_SHDN    = 8'h05;
	localparam logic [7:0] OFS_SERIAL  = 8'h07;
	localparam logic [7:0] PAGE_ZERO   = 8'h00;
	localparam logic [7:0] RST_PAGE    = 8'h00;
	localparam logic [7:0] RST_SLEEP   = 8'h00;
	localparam logic [7:0] RST_SHDN    = 8'h05;
	localparam logic [7:0] RST_SERIAL  = 8'h30;
	// Writable bits; the rest are read-only reserved and stay at reset
	localparam logic [7:0] WMASK_SLEEP = 8'hFD;
	localparam logic [7:0] WMASK_SHDN  = 8'h3F;

	// ---------------------------------------------------------------
	// Field positions
	// ---------------------------------------------------------------
	localparam int SUPPLY_SEL_BIT = 7;
	localparam int REF_PRE_LSB    = 3;
	localparam int BCAST_BIT      = 2;
	localparam int SLEEP_EXIT_BIT = 0;
	localparam int INCAP_PRE_LSB  = 4;
	localparam int PROTO_LSB      = 6;
	localparam int WLEN_LSB       = 4;
	localparam int FS_POL_BIT     = 3;
	localparam int BIT_CLOCK_POLARITY_BIT   = 2;
	localparam int TX_EDGE_BIT    = 1;
	localparam int FILL_BIT       = 0;
	localparam int RESTORE_BIT    = 0;

	// ---------------------------------------------------------------
	// Encodings
	// ---------------------------------------------------------------
	localparam logic [6:0] BCAST_ADDR  = 7'h4C;
	localparam logic [1:0] PROTO_TDM   = 2'h0;
	localparam logic [1:0] PROTO_I2S   = 2'h1;
	localparam logic [1:0] PROTO_LJ    = 2'h2;
	localparam logic [6:0] POS_HOLD    = 7'h40;
	localparam logic [6:0] I2S_LEAD    = 7'h7F;
	localparam logic [6:0] WBITS_16    = 7'h10;
	localparam logic [6:0] WBITS_20    = 7'h14;
	localparam logic [6:0] WBITS_24    = 7'h18;
	localparam logic [6:0] WBITS_32    = 7'h20;

	// ---------------------------------------------------------------
	// Precharge times and their cycle counts
	// ---------------------------------------------------------------
	localparam real CLK_MHZ      = 25.0;
	localparam real REF_T0_MS    = 3.5;
	localparam real REF_T1_MS    = 10.0;
	localparam real REF_T2_MS    = 50.0;
	localparam real REF_T3_MS    = 100.0;
	localparam real INCAP_T0_MS  = 2.5;
	localparam real INCAP_T1_MS  = 12.5;
	localparam real INCAP_T2_MS  = 25.0;
	localparam real INCAP_T3_MS  = 50.0;
	localparam int  REF_CYC_0    = int'(REF_T0_MS * 1000.0 * CLK_MHZ);
	localparam int  REF_CYC_1    = int'(REF_T1_MS * 1000.0 * CLK_MHZ);
	localparam int  REF_CYC_2    = int'(REF_T2_MS * 1000.0 * CLK_MHZ);
	localparam int  REF_CYC_3    = int'(REF_T3_MS * 1000.0 * CLK_MHZ);
	localparam int  INCAP_CYC_0  = int'(INCAP_T0_MS * 1000.0 * CLK_MHZ);
	localparam int  INCAP_CYC_1  = int'(INCAP_T1_MS * 1000.0 * CLK_MHZ);
	localparam int  INCAP_CYC_2  = int'(INCAP_T2_MS * 1000.0 * CLK_MHZ);
	localparam int  INCAP_CYC_3  = int'(INCAP_T3_MS * 1000.0 * CLK_MHZ);

endpackage : power_serial_pkg

// File: serial_frame_tx.sv
// Serial port transmitter: frame detection, slot counting and data launch
`timescale 1ns/100ps
module serial_frame_tx (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        ce,
	input  wire logic        bclk_pin,
	input  wire logic        frame_sync_pin,
	input  wire logic        enable,
	input  wire logic [31:0] left_word,
	input  wire logic [31:0] right_word,
	input  wire logic [1:0]  protocol,
	input  wire logic [1:0]  wlen,
	input  wire logic        fs_pol,
	input  wire logic        bit_clock_polarity,
	input  wire logic        tx_edge,
	input  wire logic        fill_hiz,
	output logic             dout,
	output logic             dout_oe
);

	function automatic logic [6:0] slot_bits(input logic [1:0] code);
		unique case (code)
			2'h0: slot_bits = power_serial_pkg::WBITS_16;
			2'h1: slot_bits = power_serial_pkg::WBITS_20;
			2'h2: slot_bits = power_serial_pkg::WBITS_24;
			2'h3: slot_bits = power_serial_pkg::WBITS_32;
		endcase
	endfunction : slot_bits

	logic        bclk_m_r, bclk_s_r, bclk_d_r, fs_m_r, fs_s_r, fs_last_r, slot_r;
	logic [6:0]  pos_r;
	logic [31:0] word_r;

	// ---------------------------------------------------------------
	// Edge and frame decode
	// ---------------------------------------------------------------
	wire        bclk_n      = bclk_s_r ^ bit_clock_polarity;
	wire        bclk_nd     = bclk_d_r ^ bit_clock_polarity;
	wire        sample_edge = bclk_n & ~bclk_nd;
	wire        def_launch  = ~bclk_n & bclk_nd;
	wire        launch_edge = tx_edge ? sample_edge : def_launch;
	wire        fs_n        = fs_s_r ^ fs_pol;
	wire        fs_rise     = fs_n & ~fs_last_r;
	wire        fs_fall     = ~fs_n & fs_last_r;
	wire        is_tdm      = protocol == power_serial_pkg::PROTO_TDM;
	wire        is_i2s      = protocol == power_serial_pkg::PROTO_I2S;
	wire        is_lj       = protocol == power_serial_pkg::PROTO_LJ;
	wire [6:0]  wbits       = slot_bits(wlen);
	wire        start_left  = sample_edge & (((is_tdm | is_lj) & fs_rise) | (is_i2s & fs_fall));
	wire        start_right = sample_edge & ((is_lj & fs_fall) | (is_i2s & fs_rise));
	wire        tdm_next    = sample_edge & is_tdm & ~slot_r & (pos_r == wbits - 7'h01) & ~start_left;
	wire        load        = start_left | start_right | tdm_next;
	wire        hold        = ~sample_edge | (pos_r == power_serial_pkg::POS_HOLD);
	// I2S puts the MSB one bit clock after the frame-sync edge
	wire [6:0]  pos_nxt     = load ? (is_i2s ? power_serial_pkg::I2S_LEAD : 7'h00) :
	                          hold ? pos_r : pos_r + 7'h01;
	wire        slot_nxt    = start_left ? 1'b0 : (load ? 1'b1 : slot_r);
	wire [31:0] word_nxt    = load ? (slot_nxt ? right_word : left_word) : word_r;
	wire        valid_nxt   = pos_nxt < wbits;
	wire [4:0]  bit_idx     = 5'h1F - pos_nxt[4:0];
	wire        bit_nxt     = word_nxt[bit_idx];

	// ---------------------------------------------------------------
	// State
	// ---------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			{bclk_m_r, bclk_s_r, bclk_d_r, fs_m_r, fs_s_r, fs_last_r} <= 6'h00;
			slot_r  <= 1'b0;
			pos_r   <= power_serial_pkg::POS_HOLD;
			word_r  <= 32'h0000_0000;
			dout    <= 1'b0;
			dout_oe <= 1'b0;
		end else if (ce) begin
			{bclk_m_r, bclk_s_r, bclk_d_r} <= {bclk_pin, bclk_m_r, bclk_s_r};
			{fs_m_r, fs_s_r}               <= {frame_sync_pin, fs_m_r};
			if (sample_edge)
				fs_last_r <= fs_n;
			pos_r  <= pos_nxt;
			slot_r <= slot_nxt;
			word_r <= word_nxt;
			if (!enable) begin
				dout    <= 1'b0;
				dout_oe <= 1'b0;
			end else if (launch_edge) begin
				dout    <= valid_nxt & bit_nxt;
				dout_oe <= valid_nxt | ~fill_hiz;
			end
		end
	end

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	property p_fill_hiz;
		ce && enable && launch_edge && fill_hiz && !valid_nxt |=> !dout_oe;
	endproperty
	a_fill_hiz: assert property (p_fill_hiz) else $error("unused cycle not released");

	property p_fill_low;
		ce && enable && launch_edge && !fill_hiz && !valid_nxt |=> dout_oe && !dout;
	endproperty
	a_fill_low: assert property (p_fill_low) else $error("unused cycle not driven low");

	property p_launch_only;
		$changed(dout) |-> $past(launch_edge && ce) || $past(!enable);
	endproperty
	a_launch_only: assert property (p_launch_only) else $error("data moved off the launch edge");

	property p_i2s_lead;
		ce && start_left && is_i2s |=> pos_r == power_serial_pkg::I2S_LEAD ##1 !slot_r;
	endproperty
	a_i2s_lead: assert property (p_i2s_lead) else $error("I2S slot lacks one-bit lead");

	c_hiz_gap: cover property (ce && enable && launch_edge && fill_hiz && !valid_nxt);

endmodule : serial_frame_tx

// File: power_and_serial_format_regs.sv
// Control-bus register bank with power sequencing and serial output framing
`timescale 1ns/100ps
module power_and_serial_format_regs #(
	parameter logic [6:0] TARGET_ADDR = 7'h48, // arbitrary default
	parameter int REF_CYC_0   = power_serial_pkg::REF_CYC_0,
	parameter int REF_CYC_1   = power_serial_pkg::REF_CYC_1,
	parameter int REF_CYC_2   = power_serial_pkg::REF_CYC_2,
	parameter int REF_CYC_3   = power_serial_pkg::REF_CYC_3,
	parameter int INCAP_CYC_0 = power_serial_pkg::INCAP_CYC_0,
	parameter int INCAP_CYC_1 = power_serial_pkg::INCAP_CYC_1,
	parameter int INCAP_CYC_2 = power_serial_pkg::INCAP_CYC_2,
	parameter int INCAP_CYC_3 = power_serial_pkg::INCAP_CYC_3
) (
	input  wire logic        CORE_CLK,
	input  wire logic        RST,
	input  wire logic        CE,
	input  wire logic        SCL,
	input  wire logic        SDA_IN,
	output logic             SDA_OUT,
	output logic             SDA_OE,
	input  wire logic        BIT_CLOCK,
	input  wire logic        FRAME_SYNC_PIN,
	input  wire logic [31:0] LEFT_SAMPLE,
	input  wire logic [31:0] RIGHT_SAMPLE,
	output logic             SDOUT,
	output logic             SDOUT_OE,
	output logic             ANALOG_SUPPLY_SOURCE_SELECT,
	output logic             SLEEP_ACTIVE,
	output logic             REF_PRECHARGE_ACTIVE,
	output logic             INCAP_PRECHARGE_ACTIVE
);

	typedef enum logic [3:0] {ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_PTR, ST_PTR_ACK,
	                          ST_WR, ST_WR_ACK, ST_RD, ST_RD_ACK} bus_state_type;
	typedef enum logic [1:0] {PC_IDLE, PC_REF, PC_INCAP} precharge_type;

	function automatic logic [31:0] pick_cycles(input logic [1:0] code, input int c0, input int c1,
	                                            input int c2, input int c3);
		unique case (code)
			2'h0: pick_cycles = 32'(c0);
			2'h1: pick_cycles = 32'(c1);
			2'h2: pick_cycles = 32'(c2);
			2'h3: pick_cycles = 32'(c3);
		endcase
	endfunction : pick_cycles

	bus_state_type state_r;
	precharge_type pc_r, pc_nxt;
	logic          scl_m_r, scl_s_r, scl_d_r, sda_m_r, sda_s_r, sda_d_r;
	logic [2:0]    bitcnt_r;
	logic [6:0]    shreg_r;
	logic [7:0]    ptr_r, txbyte_r, page_r, sleep_r, shdn_r, serial_r;
	logic          rw_r, held_r, sda_low_r, awake_d_r;
	logic [31:0]   cnt_r, cnt_nxt;

	// ---------------------------------------------------------------
	// Control bus pin synchronisers
	// ---------------------------------------------------------------
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			{scl_m_r, scl_s_r, scl_d_r} <= 3'h7;
			{sda_m_r, sda_s_r, sda_d_r} <= 3'h7;
		end else if (CE) begin
			{scl_m_r, scl_s_r, scl_d_r} <= {SCL, scl_m_r, scl_s_r};
			{sda_m_r, sda_s_r, sda_d_r} <= {SDA_IN, sda_m_r, sda_s_r};
		end
	end

	// ---------------------------------------------------------------
	// Decode
	// ---------------------------------------------------------------
	wire       scl_rise   = scl_s_r & ~scl_d_r;
	wire       scl_fall   = ~scl_s_r & scl_d_r;
	wire       start_seen = scl_s_r & scl_d_r & sda_d_r & ~sda_s_r;
	wire       stop_seen  = scl_s_r & scl_d_r & ~sda_d_r & sda_s_r;
	wire [7:0] rx_byte    = {shreg_r, sda_s_r};
	wire       byte_done  = scl_rise & (bitcnt_r == 3'h7);
	wire       bcast_hit  = sleep_r[power_serial_pkg::BCAST_BIT] &
	                        (rx_byte[7:1] == power_serial_pkg::BCAST_ADDR);
	wire       addr_hit   = (rx_byte[7:1] == TARGET_ADDR) | bcast_hit;
	wire       page0      = page_r == power_serial_pkg::PAGE_ZERO;
	wire       sel_page   = ptr_r == power_serial_pkg::OFS_PAGE;
	wire       sel_rest   = page0 & (ptr_r == power_serial_pkg::OFS_RESTORE);
	wire       sel_sleep  = page0 & (ptr_r == power_serial_pkg::OFS_SLEEP);
	wire       sel_shdn   = page0 & (ptr_r == power_serial_pkg::OFS_SHDN);
	wire       sel_serial = page0 & (ptr_r == power_serial_pkg::OFS_SERIAL);
	wire       wr_fire    = byte_done & (state_r == ST_WR);
	wire       restore    = wr_fire & sel_rest & rx_byte[power_serial_pkg::RESTORE_BIT];
	// Restore bit self-clears, so its register always reads zero
	wire [7:0] rd_data    = sel_page   ? page_r :
	                        sel_sleep  ? sleep_r :
	                        sel_shdn   ? shdn_r :
	                        sel_serial ? serial_r : 8'h00;
	wire       awake      = sleep_r[power_serial_pkg::SLEEP_EXIT_BIT];

	// ---------------------------------------------------------------
	// Registers
	// ---------------------------------------------------------------
	always_ff @(posedge CORE_CLK) begin
		if (RST || (CE && restore)) begin
			page_r   <= power_serial_pkg::RST_PAGE;
			sleep_r  <= power_serial_pkg::RST_SLEEP;
			shdn_r   <= power_serial_pkg::RST_SHDN;
			serial_r <= power_serial_pkg::RST_SERIAL;
		end else if (CE && wr_fire) begin
			if (sel_page)
				page_r <= rx_byte;
			if (sel_sleep)
				sleep_r <= rx_byte & power_serial_pkg::WMASK_SLEEP;
			if (sel_shdn)
				shdn_r <= rx_byte & power_serial_pkg::WMASK_SHDN;
			if (sel_serial)
				serial_r <= rx_byte;
		end
	end

	// ---------------------------------------------------------------
	// Control bus target
	// ---------------------------------------------------------------
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			state_r   <= ST_IDLE;
			bitcnt_r  <= 3'h0;
			shreg_r   <= 7'h00;
			ptr_r     <= 8'h00;
			txbyte_r  <= 8'h00;
			rw_r      <= 1'b0;
			held_r    <= 1'b0;
			sda_low_r <= 1'b0;
		end else if (CE) begin
			if (start_seen) begin
				state_r   <= ST_ADDR;
				bitcnt_r  <= 3'h0;
				held_r    <= 1'b0;
				sda_low_r <= 1'b0;
			end else if (stop_seen) begin
				state_r   <= ST_IDLE;
				held_r    <= 1'b0;
				sda_low_r <= 1'b0;
			end else begin
				if (scl_rise) begin
					shreg_r  <= rx_byte[6:0];
					bitcnt_r <= bitcnt_r + 3'h1;
				end
				unique case (state_r)
					ST_IDLE: begin
					end
					ST_ADDR: if (byte_done) begin
						rw_r    <= rx_byte[0];
						state_r <= addr_hit ? ST_ADDR_ACK : ST_IDLE;
					end
					ST_PTR: if (byte_done) begin
						ptr_r   <= rx_byte;
						state_r <= ST_PTR_ACK;
					end
					ST_WR: if (byte_done) begin
						ptr_r   <= ptr_r + 8'h01;
						state_r <= ST_WR_ACK;
					end
					ST_ADDR_ACK, ST_PTR_ACK, ST_WR_ACK: if (scl_fall) begin
						if (!held_r) begin
							held_r    <= 1'b1;
							sda_low_r <= 1'b1;
						end else begin
							held_r   <= 1'b0;
							bitcnt_r <= 3'h0;
							if (state_r == ST_ADDR_ACK && rw_r) begin
								txbyte_r  <= rd_data;
								ptr_r     <= ptr_r + 8'h01;
								sda_low_r <= ~rd_data[7];
								state_r   <= ST_RD;
							end else begin
								sda_low_r <= 1'b0;
								state_r   <= (state_r == ST_ADDR_ACK) ? ST_PTR : ST_WR;
							end
						end
					end
					ST_RD: begin
						if (scl_fall)
							sda_low_r <= ~txbyte_r[3'h7 - bitcnt_r];
						if (byte_done)
							state_r <= ST_RD_ACK;
					end
					ST_RD_ACK: begin
						if (scl_fall && !held_r) begin
							held_r    <= 1'b1;
							sda_low_r <= 1'b0;
						end else if (scl_rise && held_r && sda_s_r) begin
							held_r  <= 1'b0;
							state_r <= ST_IDLE;
						end else if (scl_fall && held_r) begin
							held_r    <= 1'b0;
							bitcnt_r  <= 3'h0;
							txbyte_r  <= rd_data;
							ptr_r     <= ptr_r + 8'h01;
							sda_low_r <= ~rd_data[7];
							state_r   <= ST_RD;
						end
					end
				endcase
			end
		end
	end

	assign SDA_OUT = 1'b0;
	assign SDA_OE  = sda_low_r;

	// ---------------------------------------------------------------
	// Precharge sequencing on leaving sleep
	// ---------------------------------------------------------------
	wire [31:0] ref_len   = pick_cycles(sleep_r[power_serial_pkg::REF_PRE_LSB +: 2],
	                                    REF_CYC_0, REF_CYC_1, REF_CYC_2, REF_CYC_3);
	wire [31:0] incap_len = pick_cycles(shdn_r[power_serial_pkg::INCAP_PRE_LSB +: 2],
	                                    INCAP_CYC_0, INCAP_CYC_1, INCAP_CYC_2, INCAP_CYC_3);

	always_comb begin
		pc_nxt  = pc_r;
		cnt_nxt = cnt_r;
		if (!awake) begin
			pc_nxt  = PC_IDLE;
			cnt_nxt = 32'h0000_0000;
		end else if (!awake_d_r) begin
			pc_nxt  = PC_REF;
			cnt_nxt = ref_len - 32'h0000_0001;
		end else if (pc_r != PC_IDLE) begin
			if (cnt_r != 32'h0000_0000) begin
				cnt_nxt = cnt_r - 32'h0000_0001;
			end else if (pc_r == PC_REF) begin
				pc_nxt  = PC_INCAP;
				cnt_nxt = incap_len - 32'h0000_0001;
			end else begin
				pc_nxt = PC_IDLE;
			end
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			pc_r      <= PC_IDLE;
			cnt_r     <= 32'h0000_0000;
			awake_d_r <= 1'b0;
		end else if (CE) begin
			pc_r      <= pc_nxt;
			cnt_r     <= cnt_nxt;
			awake_d_r <= awake;
		end
	end

	assign ANALOG_SUPPLY_SOURCE_SELECT = sleep_r[power_serial_pkg::SUPPLY_SEL_BIT];
	assign SLEEP_ACTIVE                = ~awake;
	assign REF_PRECHARGE_ACTIVE        = pc_r == PC_REF;
	assign INCAP_PRECHARGE_ACTIVE      = pc_r == PC_INCAP;

	// ---------------------------------------------------------------
	// Serial port
	// ---------------------------------------------------------------
	serial_frame_tx u_tx (
		.clk            (CORE_CLK),
		.rst            (RST),
		.ce             (CE),
		.bclk_pin       (BIT_CLOCK),
		.frame_sync_pin (FRAME_SYNC_PIN),
		.enable         (awake),
		.left_word      (LEFT_SAMPLE),
		.right_word     (RIGHT_SAMPLE),
		.protocol       (serial_r[power_serial_pkg::PROTO_LSB +: 2]),
		.wlen           (serial_r[power_serial_pkg::WLEN_LSB +: 2]),
		.fs_pol         (serial_r[power_serial_pkg::FS_POL_BIT]),
		.bit_clock_polarity       (serial_r[power_serial_pkg::BIT_CLOCK_POLARITY_BIT]),
		.tx_edge        (serial_r[power_serial_pkg::TX_EDGE_BIT]),
		.fill_hiz       (serial_r[power_serial_pkg::FILL_BIT]),
		.dout           (SDOUT),
		.dout_oe        (SDOUT_OE)
	);

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	logic [31:0] run_r, ref_lat_r, incap_lat_r;
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			run_r       <= 32'h0000_0000;
			ref_lat_r   <= 32'h0000_0000;
			incap_lat_r <= 32'h0000_0000;
		end else if (CE) begin
			run_r <= (pc_nxt != pc_r) ? 32'h0000_0000 : run_r + 32'h0000_0001;
			if (pc_nxt == PC_REF && pc_r != PC_REF)
				ref_lat_r <= ref_len;
			if (pc_nxt == PC_INCAP && pc_r != PC_INCAP)
				incap_lat_r <= incap_len;
		end
	end

	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (RST);

	property p_start_asleep;
		$fell(RST) |-> SLEEP_ACTIVE && !REF_PRECHARGE_ACTIVE && !INCAP_PRECHARGE_ACTIVE;
	endproperty
	a_start_asleep: assert property (p_start_asleep) else $error("device not asleep after reset");

	property p_supply_write;
		CE && wr_fire && sel_sleep |=> ANALOG_SUPPLY_SOURCE_SELECT == $past(rx_byte[7]);
	endproperty
	a_supply_write: assert property (p_supply_write) else $error("supply select not written");

	property p_ref_len;
		CE && pc_r == PC_REF && pc_nxt == PC_INCAP |-> run_r == ref_lat_r - 32'h0000_0001;
	endproperty
	a_ref_len: assert property (p_ref_len) else $error("reference precharge wrong length");

	property p_incap_len;
		CE && pc_r == PC_INCAP && pc_nxt == PC_IDLE && awake |-> run_r == incap_lat_r - 32'h0000_0001;
	endproperty
	a_incap_len: assert property (p_incap_len) else $error("input cap precharge wrong length");

	property p_bcast_gate;
		CE && state_r == ST_ADDR && byte_done && rx_byte[7:1] == power_serial_pkg::BCAST_ADDR &&
			TARGET_ADDR != power_serial_pkg::BCAST_ADDR
			|=> state_r == ($past(sleep_r[power_serial_pkg::BCAST_BIT]) ? ST_ADDR_ACK : ST_IDLE);
	endproperty
	a_bcast_gate: assert property (p_bcast_gate) else $error("broadcast address handled wrongly");

	property p_page_gate;
		CE && wr_fire && !page0 && !sel_page |=> $stable(serial_r) && $stable(sleep_r);
	endproperty
	a_page_gate: assert property (p_page_gate) else $error("write leaked through foreign page");

	property p_restore;
		CE && restore |=> page_r == power_serial_pkg::RST_PAGE && sleep_r == power_serial_pkg::RST_SLEEP
			&& shdn_r == power_serial_pkg::RST_SHDN && serial_r == power_serial_pkg::RST_SERIAL;
	endproperty
	a_restore: assert property (p_restore) else $error("restore left a register changed");

	property p_reserved;
		shdn_r[7:6] == 2'h0 && sleep_r[1] == 1'b0 && (!sel_rest || rd_data == 8'h00);
	endproperty
	a_reserved: assert property (p_reserved) else $error("read-only reserved bit changed");

	c_restore: cover property (CE && restore);
	c_read: cover property (state_r == ST_RD_ACK ##[1:200] state_r == ST_RD);
	c_bcast: cover property (state_r == ST_ADDR && byte_done && bcast_hit);

endmodule : power_and_serial_format_regs

// File: audio_host_model.sv
// Host audio processor model: bit clock and frame sync, left-justified framing
`timescale 1ns/100ps
module audio_host_model (
	input  wire logic run,
	output logic      bclk,
	output logic      fs
);
	int n;
	// Clock stands still between runs; it restarts with run, so its edges land on core clock falling edges
	initial begin
		bclk = 1'b0;
		fs = 1'b0;
		n = 0;
		#7;
		forever begin
			wait (run === 1'b1);
			#160 bclk = 1'b1;
			#160 bclk = 1'b0;
			n = n + 1;
			if (n == 32) begin
				n = 0;
				fs = ~fs;
			end
		end
	end
endmodule : audio_host_model

// File: tb.sv
// Self-checking bench for the power and serial-format register bank
`timescale 1ns/100ps
module tb;
	logic clk = 1'b0, rst = 1'b1, scl = 1'b1, sda_m = 1'b1, run = 1'b0, ce = 1'b1;
	logic [7:0] d;
	logic [31:0] ls = 32'hA5C35A3C;
	wire sda_w, bclk, fs, sdo, sdo_oe, sup, slp, refp, incp, sda_oe;
	int fails = 0, n_compared = 0, cyc = 0;
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin fails++; $display("MISMATCH %0t got %h exp %h", $time, a, b); end end
	// Open-drain bus line with pull-up
	assign sda_w = sda_oe ? 1'b0 : sda_m;
	initial forever #20 clk = ~clk;
	// Only the precharge codes that the scenarios reach are shortened
	power_and_serial_format_regs #(.REF_CYC_3(400), .INCAP_CYC_0(20)) dut (.CORE_CLK(clk), .RST(rst),
		.CE(ce), .SCL(scl), .SDA_IN(sda_w), .SDA_OUT(), .SDA_OE(sda_oe), .BIT_CLOCK(bclk), .FRAME_SYNC_PIN(fs),
		.LEFT_SAMPLE(ls), .RIGHT_SAMPLE(~ls), .SDOUT(sdo), .SDOUT_OE(sdo_oe), .ANALOG_SUPPLY_SOURCE_SELECT(sup),
		.SLEEP_ACTIVE(slp), .REF_PRECHARGE_ACTIVE(refp), .INCAP_PRECHARGE_ACTIVE(incp));
	audio_host_model host (.run(run), .bclk(bclk), .fs(fs));
	task wt; repeat (8) @(negedge clk); endtask : wt
	task start; sda_m = 1'b1; wt; scl = 1'b1; wt; sda_m = 1'b0; wt; scl = 1'b0; endtask : start
	task stop; wt; sda_m = 1'b0; wt; scl = 1'b1; wt; sda_m = 1'b1; wt; endtask : stop
	// Data only moves while the clock line has been low a while, never beside its fall
	task clk_bit(input logic b, output logic r); wt; sda_m = b; wt; scl = 1'b1; wt; r = sda_w; scl = 1'b0; endtask : clk_bit
	task xbyte(input logic [7:0] w, output logic [7:0] r, output logic k);
		for (int i = 7; i >= 0; i--) clk_bit(w[i], r[i]);
		clk_bit(1'b1, k);
	endtask : xbyte
	task wr(input logic [6:0] a, input logic [7:0] o, v, input logic nak);
		logic [7:0] r;
		logic k;
		start;
		xbyte({a, 1'b0}, r, k);
		`CHK(k, nak)
		if (!nak) begin
			xbyte(o, r, k);
			xbyte(v, r, k);
		end
		stop;
	endtask : wr
	task rc(input logic [7:0] o, e);
		logic [7:0] r;
		logic k;
		start;
		xbyte(8'h90, r, k);
		xbyte(o, r, k);
		start;
		xbyte(8'h91, r, k);
		xbyte(8'hFF, d, k);
		stop;
		`CHK(d, e)
	endtask : rc
	task wrap_up;
		if (fails == 0 && n_compared > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : wrap_up
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 80000) begin
			fails++;
			wrap_up;
		end
	end
	initial begin
		repeat (16) @(negedge clk);
		rst = 1'b0;
		repeat (4) @(negedge clk);
		rc(8'h02, 8'h00);
		rc(8'h05, 8'h05);
		rc(8'h07, 8'h30);
		`CHK({slp, sup}, 2'b10)
		wr(7'h4C, 8'h07, 8'h00, 1'b1);
		wr(7'h48, 8'h02, 8'h9F, 1'b0);
		`CHK({refp, sup, slp}, 3'b110)
		// A frozen core must stretch the precharge past its nominal length
		ce = 1'b0;
		repeat (500) @(negedge clk);
		`CHK(refp, 1'b1)
		ce = 1'b1;
		rc(8'h02, 8'h9D);
		repeat (500) @(negedge clk);
		`CHK({refp, incp}, 2'b00)
		wr(7'h4C, 8'h05, 8'hF5, 1'b0);
		rc(8'h05, 8'h35);
		wr(7'h48, 8'h05, 8'h15, 1'b0);
		wr(7'h48, 8'h00, 8'h01, 1'b0);
		wr(7'h48, 8'h02, 8'h00, 1'b0);
		rc(8'h02, 8'h00);
		wr(7'h48, 8'h00, 8'h00, 1'b0);
		rc(8'h02, 8'h9D);
		// Two left-justified runs, then I2S with inverted frame sync
		for (int f = 0; f < 3; f++) begin
			wr(7'h48, 8'h07, (f == 2) ? 8'h48 : 8'h80 | 8'(f), 1'b0);
			run = 1'b1;
			@(posedge fs);
			@(posedge bclk);
			for (int i = 0; i < 32; i++) begin
				@(posedge bclk);
				if (f == 2) `CHK({sdo_oe, sdo}, (i > 0 && i < 17) ? {1'b1, ls[32 - i]} : 2'b10)
				else if (i < 16) `CHK({sdo_oe, sdo}, {1'b1, ls[31 - i]})
				else if (f == 0) `CHK({sdo_oe, sdo}, 2'b10)
				else `CHK(sdo_oe, 1'b0)
			end
			@(negedge clk) run = 1'b0;
		end
		wr(7'h48, 8'h01, 8'h01, 1'b0);
		rc(8'h07, 8'h30);
		rc(8'h02, 8'h00);
		wrap_up;
	end
endmodule : tb
